// [common/swcfg_consts.svh]
// constants of the switch configuration register bank
// assumes inclusion by the package and design files only
`ifndef SWCFG_CONSTS_SVH
`define SWCFG_CONSTS_SVH

`define SWCFG_ADDR_W 8
`define SWCFG_DATA_W 8

`define SWCFG_OFS_FAST_MODES 8'h00
`define SWCFG_OFS_SIDE_MODES 8'h01
`define SWCFG_OFS_RX_SET 8'h10
`define SWCFG_OFS_TERM_AB 8'h11
`define SWCFG_OFS_TERM_CD 8'h12
`define SWCFG_OFS_EQ_AB 8'h13
`define SWCFG_OFS_EQ_CD 8'h14
`define SWCFG_OFS_TX_SET 8'h20

`define SWCFG_RST_FAST_MODES 8'h40
`define SWCFG_RST_SIDE_MODES 8'h40
`define SWCFG_RST_RX_SET 8'h01
`define SWCFG_RST_TERM_AB 8'h00
`define SWCFG_RST_TERM_CD 8'h00
`define SWCFG_RST_EQ_AB 8'h00
`define SWCFG_RST_EQ_CD 8'h00
`define SWCFG_RST_TX_SET 8'h03

`define SWCFG_MODES_EN_BIT 6
`define SWCFG_MODES_SEL_HI 1
`define SWCFG_MODES_SEL_LO 0
`define SWCFG_RX_MASTER_BIT 0
`define SWCFG_TX_BOOST_HI 3
`define SWCFG_TX_BOOST_LO 2
`define SWCFG_TX_TERM_BIT 1
`define SWCFG_TX_CUR_BIT 0

`define SWCFG_PIN_W 8
`define SWCFG_PIN_SETTLE 3'h4

`endif

// [common/swcfg_pkg.sv]
// types of the switch configuration register bank
// assumes swcfg_consts.svh on the include path
`include "swcfg_consts.svh"
package swcfg_pkg;
  typedef logic [`SWCFG_DATA_W-1:0] swcfg_byte_t;
  typedef logic [`SWCFG_ADDR_W-1:0] swcfg_addr_t;
  typedef logic [1:0] swcfg_sel_t;
  typedef enum logic [1:0] {
    SWCFG_BOOST_NONE = 2'b00,
    SWCFG_BOOST_LOW = 2'b01,
    SWCFG_BOOST_MED = 2'b10,
    SWCFG_BOOST_HIGH = 2'b11
  } swcfg_boost_t;
  typedef enum logic [1:0] {
    SWCFG_SRC_A = 2'b00,
    SWCFG_SRC_B = 2'b01,
    SWCFG_SRC_C = 2'b10,
    SWCFG_SRC_D = 2'b11
  } swcfg_src_t;
  typedef enum logic [0:0] {
    SWCFG_MODE_PIN = 1'b0,
    SWCFG_MODE_SERIAL = 1'b1
  } swcfg_mode_t;
endpackage

// [src/swcfg_sync3.sv]
// three-stage synchroniser for static configuration pins
// assumes pins are asynchronous to ref_clk_i
`timescale 1ns/100ps
module swcfg_sync3 #(
  parameter int W = 8
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] level_o
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] level_ff;
  logic [W-1:0] nxt_level;

  // a bit changes only once stages two and three agree
  always_comb begin
    for (int i = 0; i < W; i++) begin
      nxt_level[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : level_ff[i];
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      level_ff <= '0;
    end else begin
      s1_ff <= pin_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      level_ff <= nxt_level;
    end
  end

  assign level_o = level_ff;
endmodule

// [src/swcfg_lane_map.sv]
// maps sixteen per-lane control bits onto sources a..d, lane 0..3
// assumes registered input bits, so outputs are glitch-free wiring
`timescale 1ns/100ps
module swcfg_lane_map (
  input wire logic [15:0] bits_i,
  output logic [3:0] src_a_o,
  output logic [3:0] src_b_o,
  output logic [3:0] src_c_o,
  output logic [3:0] src_d_o
);
  // b ascending, a ascending, c and d descending
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      src_b_o[k] = bits_i[k];
      src_a_o[k] = bits_i[4 + k];
      src_c_o[k] = bits_i[11 - k];
      src_d_o[k] = bits_i[15 - k];
    end
  end
endmodule

// [src/swcfg_regbank.sv]
// configuration register bank of the four-to-one video link switch
// assumes a serial control front end issuing one-cycle read/write strobes
// and board-tied configuration pins
`timescale 1ns/100ps
`include "swcfg_consts.svh"
module swcfg_regbank (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // register port from the serial control front end
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire swcfg_pkg::swcfg_addr_t reg_addr_i,
  input wire swcfg_pkg::swcfg_byte_t reg_wdata_i,
  output swcfg_pkg::swcfg_byte_t reg_rdata_o,
  output logic reg_rvalid_o,
  // configuration pins
  input wire logic pin_switch_enable_i,
  input wire logic [1:0] pin_source_select_i,
  input wire logic pin_equalizer_level_i,
  input wire logic [1:0] pin_boost_level_bits_i,
  input wire logic pin_output_term_on_i,
  input wire logic pin_drive_current_sel_i,
  // controls to the channel cells
  output logic serial_mode_o,
  output logic fast_switch_enable_o,
  output swcfg_pkg::swcfg_src_t fast_source_select_o,
  output logic side_switch_enable_o,
  output swcfg_pkg::swcfg_src_t side_source_select_o,
  output logic input_term_master_select_o,
  output logic [3:0] term_src_a_o,
  output logic [3:0] term_src_b_o,
  output logic [3:0] term_src_c_o,
  output logic [3:0] term_src_d_o,
  output logic [3:0] eq_src_a_o,
  output logic [3:0] eq_src_b_o,
  output logic [3:0] eq_src_c_o,
  output logic [3:0] eq_src_d_o,
  output swcfg_pkg::swcfg_boost_t output_boost_level_o,
  output logic output_term_on_o,
  output logic output_drive_current_sel_o
);
  import swcfg_pkg::*;

  logic [`SWCFG_PIN_W-1:0] pin_raw;
  logic [`SWCFG_PIN_W-1:0] pin_lvl;
  logic p_en;
  logic [1:0] p_sel;
  logic p_eq;
  logic [1:0] p_boost;
  logic p_oterm;
  logic p_cur;

  swcfg_mode_t mode_ff;
  swcfg_mode_t nxt_mode;
  swcfg_byte_t fast_modes_ff;
  swcfg_byte_t side_modes_ff;
  swcfg_byte_t rx_set_ff;
  swcfg_byte_t term_ab_ff;
  swcfg_byte_t term_cd_ff;
  swcfg_byte_t eq_ab_ff;
  swcfg_byte_t eq_cd_ff;
  swcfg_byte_t tx_set_ff;
  swcfg_byte_t nxt_fast_modes;
  swcfg_byte_t nxt_side_modes;
  swcfg_byte_t nxt_rx_set;
  swcfg_byte_t nxt_term_ab;
  swcfg_byte_t nxt_term_cd;
  swcfg_byte_t nxt_eq_ab;
  swcfg_byte_t nxt_eq_cd;
  swcfg_byte_t nxt_tx_set;
  logic [15:0] term_eff_ff;
  logic [15:0] nxt_term_eff;
  swcfg_byte_t rdata_ff;
  swcfg_byte_t nxt_rdata;
  logic rvalid_ff;
  logic nxt_rvalid;
  swcfg_byte_t pin_fast;
  swcfg_byte_t pin_side;
  swcfg_byte_t pin_tx;
  logic access;
  logic [2:0] settle_ff;
  logic [2:0] nxt_settle;
  logic pins_settled;

  // pins are static straps but asynchronous to the clock
  assign pin_raw = {pin_switch_enable_i, pin_source_select_i, pin_equalizer_level_i,
                    pin_boost_level_bits_i, pin_output_term_on_i, pin_drive_current_sel_i};

  swcfg_sync3 #(
    .W(`SWCFG_PIN_W)
  ) u_pin_sync (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .pin_i(pin_raw),
    .level_o(pin_lvl)
  );

  assign {p_en, p_sel, p_eq, p_boost, p_oterm, p_cur} = pin_lvl;
  assign access = reg_wr_i | reg_rd_i;
  assign pins_settled = (settle_ff == `SWCFG_PIN_SETTLE);

  // pin-derived register images
  always_comb begin
    pin_fast = '0;
    pin_fast[`SWCFG_MODES_EN_BIT] = p_en;
    pin_fast[`SWCFG_MODES_SEL_HI:`SWCFG_MODES_SEL_LO] = p_sel;
    pin_side = '0;
    pin_side[`SWCFG_MODES_EN_BIT] = 1'b1;
    pin_side[`SWCFG_MODES_SEL_HI:`SWCFG_MODES_SEL_LO] = p_sel;
    pin_tx = '0;
    pin_tx[`SWCFG_TX_BOOST_HI:`SWCFG_TX_BOOST_LO] = p_boost;
    pin_tx[`SWCFG_TX_TERM_BIT] = p_oterm;
    pin_tx[`SWCFG_TX_CUR_BIT] = p_cur;
  end

  // synchroniser fill time, so reset-time zeros are never taken as straps
  always_comb begin
    nxt_settle = settle_ff;
    if (settle_ff != `SWCFG_PIN_SETTLE) begin
      nxt_settle = settle_ff + 3'h1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      settle_ff <= 3'h0;
    end else begin
      settle_ff <= nxt_settle;
    end
  end

  // mode: pins govern until the first serial access
  always_comb begin
    nxt_mode = mode_ff;
    if (access) begin
      nxt_mode = SWCFG_MODE_SERIAL;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_ff <= SWCFG_MODE_PIN;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // register contents
  always_comb begin
    nxt_fast_modes = fast_modes_ff;
    nxt_side_modes = side_modes_ff;
    nxt_rx_set = rx_set_ff;
    nxt_term_ab = term_ab_ff;
    nxt_term_cd = term_cd_ff;
    nxt_eq_ab = eq_ab_ff;
    nxt_eq_cd = eq_cd_ff;
    nxt_tx_set = tx_set_ff;
    if (mode_ff == SWCFG_MODE_PIN && pins_settled) begin
      // load from pins every cycle, so serial starts from pin values
      nxt_fast_modes = pin_fast;
      nxt_side_modes = pin_side;
      nxt_rx_set = `SWCFG_RST_RX_SET;
      nxt_term_ab = '0;
      nxt_term_cd = '0;
      nxt_eq_ab = {`SWCFG_DATA_W{p_eq}};
      nxt_eq_cd = {`SWCFG_DATA_W{p_eq}};
      nxt_tx_set = pin_tx;
    end
    if (reg_wr_i) begin
      case (reg_addr_i)
        `SWCFG_OFS_FAST_MODES: begin
          nxt_fast_modes = '0;
          nxt_fast_modes[`SWCFG_MODES_EN_BIT] = reg_wdata_i[`SWCFG_MODES_EN_BIT];
          nxt_fast_modes[`SWCFG_MODES_SEL_HI:`SWCFG_MODES_SEL_LO] =
            reg_wdata_i[`SWCFG_MODES_SEL_HI:`SWCFG_MODES_SEL_LO];
        end
        `SWCFG_OFS_SIDE_MODES: begin
          nxt_side_modes = '0;
          nxt_side_modes[`SWCFG_MODES_EN_BIT] = reg_wdata_i[`SWCFG_MODES_EN_BIT];
          nxt_side_modes[`SWCFG_MODES_SEL_HI:`SWCFG_MODES_SEL_LO] =
            reg_wdata_i[`SWCFG_MODES_SEL_HI:`SWCFG_MODES_SEL_LO];
        end
        `SWCFG_OFS_RX_SET: begin
          nxt_rx_set = '0;
          nxt_rx_set[`SWCFG_RX_MASTER_BIT] = reg_wdata_i[`SWCFG_RX_MASTER_BIT];
        end
        `SWCFG_OFS_TERM_AB: begin
          nxt_term_ab = reg_wdata_i;
        end
        `SWCFG_OFS_TERM_CD: begin
          nxt_term_cd = reg_wdata_i;
        end
        `SWCFG_OFS_EQ_AB: begin
          nxt_eq_ab = reg_wdata_i;
        end
        `SWCFG_OFS_EQ_CD: begin
          nxt_eq_cd = reg_wdata_i;
        end
        `SWCFG_OFS_TX_SET: begin
          nxt_tx_set = '0;
          nxt_tx_set[`SWCFG_TX_BOOST_HI:`SWCFG_TX_BOOST_LO] =
            reg_wdata_i[`SWCFG_TX_BOOST_HI:`SWCFG_TX_BOOST_LO];
          nxt_tx_set[`SWCFG_TX_TERM_BIT] = reg_wdata_i[`SWCFG_TX_TERM_BIT];
          nxt_tx_set[`SWCFG_TX_CUR_BIT] = reg_wdata_i[`SWCFG_TX_CUR_BIT];
        end
        default: begin
          nxt_tx_set = nxt_tx_set;
        end
      endcase
    end
  end

  // gated termination, registered so the cells see no glitch
  always_comb begin
    if (nxt_rx_set[`SWCFG_RX_MASTER_BIT]) begin
      nxt_term_eff = {nxt_term_cd, nxt_term_ab};
    end else begin
      nxt_term_eff = '0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      term_eff_ff <= '0;
    end else begin
      term_eff_ff <= nxt_term_eff;
    end
  end

  // read answer, one cycle after the strobe
  always_comb begin
    nxt_rvalid = reg_rd_i;
    nxt_rdata = rdata_ff;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `SWCFG_OFS_FAST_MODES: nxt_rdata = fast_modes_ff;
        `SWCFG_OFS_SIDE_MODES: nxt_rdata = side_modes_ff;
        `SWCFG_OFS_RX_SET: nxt_rdata = rx_set_ff;
        `SWCFG_OFS_TERM_AB: nxt_rdata = term_ab_ff;
        `SWCFG_OFS_TERM_CD: nxt_rdata = term_cd_ff;
        `SWCFG_OFS_EQ_AB: nxt_rdata = eq_ab_ff;
        `SWCFG_OFS_EQ_CD: nxt_rdata = eq_cd_ff;
        `SWCFG_OFS_TX_SET: nxt_rdata = tx_set_ff;
        default: nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_ff <= '0;
      rvalid_ff <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fast_modes_ff <= `SWCFG_RST_FAST_MODES;
      side_modes_ff <= `SWCFG_RST_SIDE_MODES;
      rx_set_ff <= `SWCFG_RST_RX_SET;
      term_ab_ff <= `SWCFG_RST_TERM_AB;
      term_cd_ff <= `SWCFG_RST_TERM_CD;
      eq_ab_ff <= `SWCFG_RST_EQ_AB;
      eq_cd_ff <= `SWCFG_RST_EQ_CD;
      tx_set_ff <= `SWCFG_RST_TX_SET;
    end else begin
      fast_modes_ff <= nxt_fast_modes;
      side_modes_ff <= nxt_side_modes;
      rx_set_ff <= nxt_rx_set;
      term_ab_ff <= nxt_term_ab;
      term_cd_ff <= nxt_term_cd;
      eq_ab_ff <= nxt_eq_ab;
      eq_cd_ff <= nxt_eq_cd;
      tx_set_ff <= nxt_tx_set;
    end
  end

  swcfg_lane_map u_term_map (
    .bits_i(term_eff_ff),
    .src_a_o(term_src_a_o),
    .src_b_o(term_src_b_o),
    .src_c_o(term_src_c_o),
    .src_d_o(term_src_d_o)
  );

  swcfg_lane_map u_eq_map (
    .bits_i({eq_cd_ff, eq_ab_ff}),
    .src_a_o(eq_src_a_o),
    .src_b_o(eq_src_b_o),
    .src_c_o(eq_src_c_o),
    .src_d_o(eq_src_d_o)
  );

  assign reg_rdata_o = rdata_ff;
  assign reg_rvalid_o = rvalid_ff;
  assign serial_mode_o = (mode_ff == SWCFG_MODE_SERIAL);
  assign fast_switch_enable_o = fast_modes_ff[`SWCFG_MODES_EN_BIT];
  assign fast_source_select_o = swcfg_src_t'(fast_modes_ff[`SWCFG_MODES_SEL_HI:`SWCFG_MODES_SEL_LO]);
  assign side_switch_enable_o = side_modes_ff[`SWCFG_MODES_EN_BIT];
  assign side_source_select_o = swcfg_src_t'(side_modes_ff[`SWCFG_MODES_SEL_HI:`SWCFG_MODES_SEL_LO]);
  assign input_term_master_select_o = rx_set_ff[`SWCFG_RX_MASTER_BIT];
  assign output_boost_level_o = swcfg_boost_t'(tx_set_ff[`SWCFG_TX_BOOST_HI:`SWCFG_TX_BOOST_LO]);
  assign output_term_on_o = tx_set_ff[`SWCFG_TX_TERM_BIT];
  assign output_drive_current_sel_o = tx_set_ff[`SWCFG_TX_CUR_BIT];
endmodule

// [bench/swcfg_monitor.sv]
// port checker of the configuration register bank
// assumes a bind onto swcfg_regbank, one clock domain
`timescale 1ns/100ps
module swcfg_monitor (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire swcfg_pkg::swcfg_addr_t reg_addr_i,
  input wire swcfg_pkg::swcfg_byte_t reg_wdata_i,
  input wire logic reg_rvalid_o,
  input wire logic serial_mode_o,
  input wire logic side_switch_enable_o,
  input wire logic input_term_master_select_o,
  input wire logic [3:0] term_src_a_o,
  input wire logic [3:0] term_src_b_o,
  input wire logic [3:0] term_src_c_o,
  input wire logic [3:0] term_src_d_o,
  input wire logic [3:0] eq_src_a_o,
  input wire logic [3:0] eq_src_b_o,
  input wire logic [3:0] eq_src_c_o,
  input wire logic [3:0] eq_src_d_o,
  input wire swcfg_pkg::swcfg_boost_t output_boost_level_o,
  input wire logic output_term_on_o,
  input wire logic output_drive_current_sel_o
);
  import swcfg_pkg::*;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  wire logic tx_wr = reg_wr_i && reg_addr_i == 8'h20;
  wire logic [15:0] term_all = {term_src_a_o, term_src_b_o, term_src_c_o, term_src_d_o};
  wire logic [15:0] eq_all = {eq_src_a_o, eq_src_b_o, eq_src_c_o, eq_src_d_o};
  wire logic [3:0] tx_all = {output_boost_level_o, output_term_on_o, output_drive_current_sel_o};
  rd_answer_a: assert property (reg_rd_i |=> reg_rvalid_o) else $error("read not answered");
  rvalid_cause_a: assert property (reg_rvalid_o |-> $past(reg_rd_i)) else $error("stray read valid");
  boost_write_a: assert property (tx_wr |=> output_boost_level_o == $past(reg_wdata_i[3:2]))
    else $error("boost not written");
  oterm_write_a: assert property (tx_wr |=> output_term_on_o == $past(reg_wdata_i[1]))
    else $error("output term not written");
  current_write_a: assert property (tx_wr |=> output_drive_current_sel_o == $past(reg_wdata_i[0]))
    else $error("current not written");
  tx_hold_a: assert property (serial_mode_o && !tx_wr |=> $stable(tx_all)) else $error("tx moved");
  mode_enter_a: assert property (reg_wr_i || reg_rd_i |=> serial_mode_o) else $error("pin mode kept");
  mode_keep_a: assert property (serial_mode_o |=> serial_mode_o) else $error("pin mode re-entered");
  pin_term_open_a: assert property (!serial_mode_o |-> term_all == 16'h0 && input_term_master_select_o)
    else $error("pin mode termination");
  master_open_a: assert property (!input_term_master_select_o |-> term_all == 16'h0)
    else $error("termination not open");
  pin_side_on_a: assert property (!serial_mode_o |-> side_switch_enable_o) else $error("side off");
  pin_eq_same_a: assert property (!serial_mode_o |-> eq_all == 16'h0 || eq_all == 16'hffff)
    else $error("pin mode eq mixed");
endmodule

// [bench/swcfg_host_model.sv]
// host controller of the register port plus board-tied straps
// assumes the bank takes a strobe at the rising edge after it is raised
`timescale 1ns/100ps
module swcfg_host_model (
  input wire logic ref_clk_i,
  input wire swcfg_pkg::swcfg_byte_t reg_rdata_i,
  input wire logic reg_rvalid_i,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output swcfg_pkg::swcfg_addr_t reg_addr_o,
  output swcfg_pkg::swcfg_byte_t reg_wdata_o,
  output logic [7:0] pins_o
);
  import swcfg_pkg::*;
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
    pins_o = 8'h00;
  end
  // straps are static levels between calls
  task automatic set_pins(input logic [7:0] p);
    pins_o = p;
  endtask
  task automatic acc(input logic w, input swcfg_addr_t a, input swcfg_byte_t d, output swcfg_byte_t q,
    output logic v);
    @(posedge ref_clk_i);
    #1;
    reg_wr_o = w;
    reg_rd_o = !w;
    reg_addr_o = a;
    reg_wdata_o = d;
    @(posedge ref_clk_i);
    #1;
    q = reg_rdata_i;
    v = reg_rvalid_i;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    // released lines carry junk
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask
endmodule

// [bench/tb_switch_config_register_bank.sv]
// self-checking bench of the configuration register bank
// assumes swcfg_host_model as host and strap source
`timescale 1ns/100ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_total++; \
  $display("unexpected t=%0t got %h exp %h", $time, a, e); end end
module tb_switch_config_register_bank;
  import swcfg_pkg::*;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic reg_wr_i, reg_rd_i, reg_rvalid_o, serial_mode_o, fast_switch_enable_o, side_switch_enable_o;
  logic input_term_master_select_o, output_term_on_o, output_drive_current_sel_o;
  swcfg_addr_t reg_addr_i;
  swcfg_byte_t reg_wdata_i, reg_rdata_o;
  swcfg_src_t fast_source_select_o, side_source_select_o;
  swcfg_boost_t output_boost_level_o;
  logic [3:0] term_src_a_o, term_src_b_o, term_src_c_o, term_src_d_o;
  logic [3:0] eq_src_a_o, eq_src_b_o, eq_src_c_o, eq_src_d_o;
  logic [7:0] pins;
  logic [7:0] p;
  int err_total = 0;
  int n_compared = 0;
  wire logic [15:0] term_all = {term_src_a_o, term_src_b_o, term_src_c_o, term_src_d_o};
  wire logic [15:0] eq_all = {eq_src_a_o, eq_src_b_o, eq_src_c_o, eq_src_d_o};
  wire logic [3:0] tx_all = {output_boost_level_o, output_term_on_o, output_drive_current_sel_o};
  always #2.5 ref_clk_i = ~ref_clk_i;
  swcfg_regbank dut (.ref_clk_i, .nrst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
    .reg_rvalid_o, .pin_switch_enable_i(pins[7]), .pin_source_select_i(pins[6:5]),
    .pin_equalizer_level_i(pins[4]), .pin_boost_level_bits_i(pins[3:2]), .pin_output_term_on_i(pins[1]),
    .pin_drive_current_sel_i(pins[0]), .serial_mode_o, .fast_switch_enable_o, .fast_source_select_o,
    .side_switch_enable_o, .side_source_select_o, .input_term_master_select_o, .term_src_a_o, .term_src_b_o,
    .term_src_c_o, .term_src_d_o, .eq_src_a_o, .eq_src_b_o, .eq_src_c_o, .eq_src_d_o, .output_boost_level_o,
    .output_term_on_o, .output_drive_current_sel_o);
  swcfg_host_model host (.ref_clk_i, .reg_rdata_i(reg_rdata_o), .reg_rvalid_i(reg_rvalid_o),
    .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i), .pins_o(pins));
  task automatic wr(input swcfg_addr_t a, input swcfg_byte_t d);
    swcfg_byte_t q;
    logic v;
    host.acc(1'b1, a, d, q, v);
  endtask
  task automatic rchk(input swcfg_addr_t a, input swcfg_byte_t e);
    swcfg_byte_t q;
    logic v;
    host.acc(1'b0, a, 8'h00, q, v);
    `CHK(v, 1'b1);
    `CHK(q, e);
  endtask
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    err_total++;
    final_report;
  end
  initial begin
    for (int k = 0; k < 2; k++) begin
      p = k ? 8'h2a : 8'hd5;
      host.set_pins(p);
      nrst_i = 1'b0;
      repeat (6) @(posedge ref_clk_i);
      #1;
      nrst_i = 1'b1;
      repeat (8) @(posedge ref_clk_i);
      #1;
      `CHK(serial_mode_o, 1'b0);
      `CHK({fast_switch_enable_o, fast_source_select_o}, p[7:5]);
      `CHK({side_switch_enable_o, side_source_select_o}, {1'b1, p[6:5]});
      `CHK({input_term_master_select_o, term_all}, 17'h10000);
      `CHK(eq_all, {16{p[4]}});
      `CHK(tx_all, p[3:0]);
      rchk(8'h00, {1'b0, p[7], 4'h0, p[6:5]});
      rchk(8'h01, {6'h10, p[6:5]});
      rchk(8'h10, 8'h01);
      rchk(8'h11, 8'h00);
      rchk(8'h14, {8{p[4]}});
      rchk(8'h20, {4'h0, p[3:0]});
      host.set_pins(~p);
      repeat (8) @(posedge ref_clk_i);
      #1;
      `CHK(eq_all, {16{p[4]}});
      rchk(8'h20, {4'h0, p[3:0]});
    end
    wr(8'h11, 8'h5a);
    wr(8'h12, 8'h3c);
    wr(8'h10, 8'hfe);
    `CHK(term_all, 16'h0);
    rchk(8'h10, 8'h00);
    wr(8'h10, 8'hff);
    `CHK(term_all, 16'h5a3c);
    rchk(8'h12, 8'h3c);
    wr(8'h13, 8'h81);
    wr(8'h14, 8'h18);
    `CHK(eq_all, 16'h8118);
    for (int i = 0; i < 16; i++) begin
      wr(8'h20, {4'ha, i[3:0]});
      `CHK(tx_all, i[3:0]);
      rchk(8'h20, {4'h0, i[3:0]});
    end
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, {6'h2f, i[1:0]});
      `CHK({fast_switch_enable_o, fast_source_select_o}, {1'b0, i[1:0]});
      rchk(8'h00, {6'h00, i[1:0]});
    end
    wr(8'h00, 8'hd3);
    `CHK({fast_switch_enable_o, fast_source_select_o}, 3'h7);
    rchk(8'h00, 8'h43);
    wr(8'h01, 8'hb6);
    `CHK({side_switch_enable_o, side_source_select_o}, 3'h2);
    rchk(8'h01, 8'h02);
    rchk(8'h13, 8'h81);
    wr(8'h30, 8'hff);
    rchk(8'h30, 8'h00);
    final_report;
  end
endmodule
bind swcfg_regbank swcfg_monitor mon (.ref_clk_i, .nrst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
  .reg_rvalid_o, .serial_mode_o, .side_switch_enable_o, .input_term_master_select_o, .term_src_a_o,
  .term_src_b_o, .term_src_c_o, .term_src_d_o, .eq_src_a_o, .eq_src_b_o, .eq_src_c_o, .eq_src_d_o,
  .output_boost_level_o, .output_term_on_o, .output_drive_current_sel_o);
